// File: rtl/ssw_exec.sv
// Execution unit for skip-if-nonzero, subtract and nibble swap operations
`timescale 1ns/10ps
module ssw_exec
  import ssw_pkg::*;
#(
  parameter int W = DATA_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Instruction issue
  input wire logic opValid,
  input wire ssw_op_t opCode,
  input wire logic [W-1:0] memData,
  input wire logic [W-1:0] immData,
  // Accumulator and flags
  output logic [W-1:0] acc,
  output logic [FLAG_W-1:0] flags,
  // Memory write back
  output logic memWrite,
  output logic [W-1:0] memWdata,
  // Sequencing
  output logic skipNext,
  output logic dummyCycle,
  output logic busy
);
  ////////////////////////////////////////////////////////////////////////
  // Sequencer states: idle takes requests, second is the skip op's extra cycle
  typedef enum logic [1:0] {SSW_IDLE, SSW_SECOND} ssw_state_t;
  ssw_state_t state, next_state;
  logic [W-1:0] next_acc, next_memWdata, subB, subDiff;
  logic [FLAG_W-1:0] next_flags, subFlags;
  logic next_memWrite, next_skipNext, next_dummyCycle, next_busy, pendSkip, next_pendSkip;
  logic take;

  // Swap the two nibbles of a byte
  function automatic logic [W-1:0] swapNib(input logic [W-1:0] v);
    swapNib = {v[NIB_W-1:0], v[W-1:NIB_W]};
  endfunction : swapNib

  // True for the three subtract variants, which all rewrite the flags
  function automatic logic isSubOp(input ssw_op_t op);
    isSubOp = (op == SSW_OP_SUB) || (op == SSW_OP_SUB_MEM) || (op == SSW_OP_SUB_IMM);
  endfunction : isSubOp

  // True for the ops whose result goes back to the memory byte
  function automatic logic writesMem(input ssw_op_t op);
    writesMem = (op == SSW_OP_SUB_MEM) || (op == SSW_OP_SWAP);
  endfunction : writesMem

  ////////////////////////////////////////////////////////////////////////
  // Request is taken only in idle; a request during the skip's second cycle is dropped
  assign take = opValid && (state == SSW_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // eight-bit modulo subtract
  assign subB = (opCode == SSW_OP_SUB_IMM) ? immData : memData;
  ssw_sub_flags #(.W(W)) uSub (
    .minuend(acc),
    .subtrahend(subB),
    .zeroPrev(flags[FLAG_Z]),
    .diff(subDiff),
    .flags(subFlags)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: next state, pending skip and the skip pulses
  always_comb begin
    next_state = state;
    next_pendSkip = 1'b0;
    next_busy = 1'b0;
    next_skipNext = 1'b0;
    next_dummyCycle = 1'b0;
    case (state)
      SSW_IDLE: begin
        // skip op takes a second cycle
        if (take && (opCode == SSW_OP_SKIP_NZ)) begin
          next_pendSkip = (memData != ZERO_BYTE);
          next_busy = 1'b1;
          next_state = SSW_SECOND;
        end
      end
      SSW_SECOND: begin
        next_skipNext = pendSkip;
        next_dummyCycle = pendSkip;
        next_state = SSW_IDLE;
      end
      default: begin
        next_state = SSW_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= SSW_IDLE;
      pendSkip <= 1'b0;
      busy <= 1'b0;
      skipNext <= 1'b0;
      dummyCycle <= 1'b0;
    end else begin
      state <= next_state;
      pendSkip <= next_pendSkip;
      busy <= next_busy;
      skipNext <= next_skipNext;
      dummyCycle <= next_dummyCycle;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Accumulator and flags: skip and swaps leave the flags as they are
  always_comb begin
    next_acc = acc;
    next_flags = flags;
    if (take) begin
      case (opCode)
        SSW_OP_SUB, SSW_OP_SUB_IMM: begin
          next_acc = subDiff;
        end
        SSW_OP_SWAP_ACC: begin
          next_acc = swapNib(memData);
        end
        default: begin
          next_acc = acc;
        end
      endcase
      if (isSubOp(opCode)) begin
        next_flags = subFlags;
      end
    end
  end

  // Accumulator and flag registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc <= ACC_RST;
      flags <= FLAGS_RST;
    end else begin
      acc <= next_acc;
      flags <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory write back: a one-cycle strobe, data held until the next write
  always_comb begin
    next_memWrite = 1'b0;
    next_memWdata = memWdata;
    if (take && writesMem(opCode)) begin
      next_memWrite = 1'b1;
      if (opCode == SSW_OP_SWAP) begin
        next_memWdata = swapNib(memData);
      end else begin
        next_memWdata = subDiff;
      end
    end
  end

  // Memory write registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      memWrite <= 1'b0;
      memWdata <= ZERO_BYTE;
    end else begin
      memWrite <= next_memWrite;
      memWdata <= next_memWdata;
    end
  end
endmodule : ssw_exec

// File: rtl/ssw_pkg.sv
// Package with opcodes, flag positions and widths for the subtract/skip/swap unit
package ssw_pkg;
  localparam int DATA_W = 8;
  localparam int FLAG_W = 6;
  localparam int NIB_W = 4;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  // Flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_X1 = 4;
  localparam int FLAG_X2 = 5;
  // Operation codes
  typedef enum logic [2:0] {
    SSW_OP_NOP = 3'h0,
    SSW_OP_SKIP_NZ = 3'h1,
    SSW_OP_SUB = 3'h2,
    SSW_OP_SUB_MEM = 3'h3,
    SSW_OP_SUB_IMM = 3'h4,
    SSW_OP_SWAP = 3'h5,
    SSW_OP_SWAP_ACC = 3'h6
  } ssw_op_t;
endpackage : ssw_pkg

// File: rtl/ssw_sub_flags.sv
// Combinational subtractor producing difference and status flags
`timescale 1ns/10ps
module ssw_sub_flags
  import ssw_pkg::*;
#(
  parameter int W = DATA_W
) (
  // Operands
  input wire logic [W-1:0] minuend,
  input wire logic [W-1:0] subtrahend,
  input wire logic zeroPrev,
  // Results
  output logic [W-1:0] diff,
  output logic [FLAG_W-1:0] flags
);
  logic [W:0] full;
  logic [NIB_W:0] low;
  // Subtract with no-borrow carry and flag derivation
  always_comb begin
    full = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, 1'b1};
    low = {1'b0, minuend[NIB_W-1:0]} + {1'b0, ~subtrahend[NIB_W-1:0]} + {{NIB_W{1'b0}}, 1'b1};
    diff = full[W-1:0];
    flags = FLAGS_RST;
    flags[FLAG_C] = full[W];
    flags[FLAG_AC] = low[NIB_W];
    flags[FLAG_Z] = (full[W-1:0] == {W{1'b0}});
    flags[FLAG_OV] = (minuend[W-1] != subtrahend[W-1]) && (full[W-1] != minuend[W-1]);
    flags[FLAG_X1] = flags[FLAG_OV] ^ full[W-1];
    flags[FLAG_X2] = flags[FLAG_Z] & zeroPrev;
  end
endmodule : ssw_sub_flags

// File: tb/ssw_exec_chk.sv
// Port assertions for the subtract, skip and swap unit
`timescale 1ns/10ps
module ssw_exec_chk
  import ssw_pkg::*;
#(parameter int W = DATA_W) (
  // Clock, reset and strobes
  input wire logic clk, reset_n, opValid, memWrite, skipNext, dummyCycle, busy,
  // Codes, bytes and flags
  input wire ssw_op_t opCode,
  input wire logic [W-1:0] memData, immData, acc, memWdata,
  input wire logic [FLAG_W-1:0] flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Taken request and swapped byte
  wire logic tk = opValid && !busy;
  wire logic [W-1:0] swp = {memData[3:0], memData[7:4]};
  a_skip_taken:
  assert property (tk && opCode == SSW_OP_SKIP_NZ |=> busy ##1 skipNext == |$past(memData, 2)) else $error("skip");
  a_skip_quiet:
  assert property (tk && opCode == SSW_OP_SKIP_NZ |=> $stable(flags) && $stable(acc) && !memWrite) else $error("skipq");
  a_dummy_pair:
  assert property ((skipNext || dummyCycle) |-> skipNext && dummyCycle && $past(busy)) else $error("dummy");
  a_sub_acc:
  assert property (tk && opCode == SSW_OP_SUB |=> acc == $past(acc) - $past(memData) && !memWrite) else $error("sub");
  a_sub_flags:
  assert property (tk && opCode == SSW_OP_SUB |=> flags[FLAG_C] == ($past(acc) >= $past(memData))
    && flags[FLAG_Z] == ($past(acc) == $past(memData))) else $error("flags");
  a_sub_mem:
  assert property (tk && opCode == SSW_OP_SUB_MEM |=> memWrite
    && memWdata == $past(acc) - $past(memData) && $stable(acc)) else $error("submem");
  a_sub_imm:
  assert property (tk && opCode == SSW_OP_SUB_IMM |=> acc == $past(acc) - $past(immData)) else $error("subimm");
  a_swap_mem:
  assert property (tk && opCode == SSW_OP_SWAP |=> memWrite && memWdata == $past(swp) && $stable(flags)) else $error("swap");
  a_swap_acc:
  assert property (tk && opCode == SSW_OP_SWAP_ACC |=> acc == $past(swp) && !memWrite && $stable(flags)) else $error("nibble_exchange_to_acc_op");
  // Main scenarios reached
  c_skip: cover property (skipNext);
  c_refused: cover property (busy && opValid);
  c_ovf: cover property (flags[FLAG_OV]);
endmodule : ssw_exec_chk

// File: tb/ssw_exec_tb_top.sv
// Bench for the subtract, skip and swap unit
`timescale 1ns/10ps
module ssw_exec_tb_top
  import ssw_pkg::*;
;
  logic clk = 0, reset_n = 0, opValid = 0, memWrite, skipNext, dummyCycle, busy;
  ssw_op_t opCode = SSW_OP_NOP;
  logic [7:0] memData = 8'h00, immData = 8'h00, acc, memWdata, ea = 8'h00, ef = 8'h00, sv;
  logic [5:0] flags;
  logic [7:0] em = 8'h00;
  logic ew = 1'b0;
  int errors = 0, n_checks = 0;
  ssw_exec i_dut (.*);
  // Clock of 100 ns
  initial forever #50 clk = ~clk;
  // Compare seen with expected
  task automatic chk(string nm, logic [7:0] s, e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // Expected flags after a minus b
  function automatic logic [7:0] fl(logic [7:0] a, b, logic zp);
    logic [7:0] d = a - b;
    logic v = a[7] != b[7] && d[7] != a[7];
    return {2'h0, d == 8'h00 && zp, v ^ d[7], v, d == 8'h00, a[3:0] >= b[3:0], a >= b};
  endfunction : fl
  // Counts and verdict
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // Corner then random operations, back to back
  initial begin
    void'($urandom(38389));
    repeat (20) @(negedge clk);
    reset_n = 1;
    for (int i = 0; i < 300; i++) begin
      opCode = ssw_op_t'(i < 12 ? i % 6 + 1 : $urandom_range(6, 0));
      memData = i < 6 ? 8'h00 : i < 12 ? 8'h80 : 8'($urandom);
      immData = 8'($urandom);
      opValid = 1;
      sv = opCode == SSW_OP_SUB_IMM ? immData : memData;
      ew = opCode inside {SSW_OP_SUB_MEM, SSW_OP_SWAP};
      if (opCode == SSW_OP_SUB_MEM) em = ea - sv;
      if (opCode == SSW_OP_SWAP) em = {memData[3:0], memData[7:4]};
      if (opCode inside {[SSW_OP_SUB:SSW_OP_SUB_IMM]}) ef = fl(ea, sv, ef[FLAG_Z]);
      if (opCode inside {SSW_OP_SUB, SSW_OP_SUB_IMM}) ea = ea - sv;
      if (opCode == SSW_OP_SWAP_ACC) ea = {memData[3:0], memData[7:4]};
      @(negedge clk);
      chk("acc", acc, ea);
      chk("flags", {2'h0, flags}, ef);
      chk("memWrite", 8'(memWrite), 8'(ew));
      chk("memWdata", memWdata, em);
      chk("seq", 8'({skipNext, dummyCycle}), 8'h00);
      if (opCode == SSW_OP_SKIP_NZ) begin
        opCode = SSW_OP_SUB;
        chk("busy", 8'(busy), 8'h01);
        @(negedge clk);
        chk("skip", 8'({skipNext, dummyCycle}), {6'h00, {2{|memData}}});
        chk("acc", acc, ea);
        chk("memWrite", 8'(memWrite), 8'h00);
      end
    end
    stop_test();
  end
endmodule : ssw_exec_tb_top
bind ssw_exec ssw_exec_chk #(.W(W)) i_chk (.*);
